// ---- dcc_cmp_model.sv ----
// behavioural pair of analog comparators in front of the control block
// assumes 8-bit level codes from the bench and the reference select pin
`timescale 1ns/1ps
`default_nettype none
module dcc_cmp_model
(
  input  wire logic [7:0] plus1,
  input  wire logic [7:0] minus1,
  input  wire logic [7:0] plus2,
  input  wire logic [7:0] minus2,
  input  wire logic       vref_sel,
  input  wire logic [7:0] vref_lvl,
  output logic            raw1,
  output logic            raw2
);
  // reference select puts the internal level on both plus inputs
  assign raw1 = ((vref_sel ? vref_lvl : plus1) > minus1);
  assign raw2 = ((vref_sel ? vref_lvl : plus2) > minus2);
endmodule
`default_nettype wire

// ---- dcc_regs.vh ----
// register indices, field positions, mode codes and reset values of the
// dual comparator control block; byte address is four times the index
`ifndef DCC_REGS_VH
`define DCC_REGS_VH

// ----------------------------------------
// register indices
// ----------------------------------------
`define DCC_IDX_INTCTL 8'h0B
`define DCC_IDX_FLAGS  8'h0C
`define DCC_IDX_CTL    8'h1F
`define DCC_IDX_PDAT   8'h05
`define DCC_IDX_PDIR   8'h85
`define DCC_IDX_PEN    8'h8C

// ----------------------------------------
// field positions
// ----------------------------------------
`define DCC_GIE_BIT   7
`define DCC_PERIPHERAL_INT_ENABLE_BIT  6
`define DCC_FLAG_BIT  6
`define DCC_EN_BIT    6
`define DCC_INV2_BIT  5
`define DCC_INV1_BIT  4
`define DCC_CIS_BIT   3
`define DCC_LINE3_BIT 3
`define DCC_LINE4_BIT 4

// ----------------------------------------
// comparator modes
// ----------------------------------------
`define DCC_MODE_RESET 3'h0
`define DCC_MODE_OUT_A 3'h1
`define DCC_MODE_VREF  3'h2
`define DCC_MODE_OUT_B 3'h6
`define DCC_MODE_OFF   3'h7

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define DCC_RST_CTL    8'h00
`define DCC_RST_FLAGS  8'h00
`define DCC_RST_PEN    8'h00
`define DCC_RST_INTCTL 8'h00
`define DCC_RST_PDIR   8'hFF
`define DCC_RST_PDAT   8'h00
`define DCC_MASK_RSVD  8'hF7

`endif

// ---- dcc_top.v ----
// dual comparator control: registers, change flag, pin steering
// assumes an apb master on sys_clk and async comparator and pin levels
//
// What this block does
// - result is high when plus input exceeds minus input, before inversion.
// - mode 010 routes internal reference to both plus inputs.
// - both results read in control bits 7:6; writes to them ignored.
// - modes 110 and 001 drive raw results on port lines three, four.
// - direction bits still enable outputs of lines three and four.
// - port data read returns 0 on pins that are analog inputs.
// - change flag, flags bit 6, set when either result changes.
// - flag cleared only by writing zero; writing one sets it.
// - interrupt needs all three enables; flag sets regardless.
// - mismatch keeps setting flag; any control access ends mismatch.
// - a change during a control access may not set the flag.
// - comparators run in sleep; enabled change interrupt wakes device.
// - waking from sleep leaves the control register unchanged.
// - reset loads control with zero, mode 000, comparators off.
// - each invert bit inverts its reported and driven result.
// - input switch picks minus input source in modes 001 and 010.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_regs.vh"

module dcc_top
(
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        cmp1_raw,
  input  wire        cmp2_raw,
  input  wire [7:0]  port_a_pins,
  input  wire        sleep_mode,
  output reg         line3_out,
  output reg         line3_oe,
  output reg         line4_out,
  output reg         line4_oe,
  output reg         cmp_power_on,
  output reg         vref_to_plus,
  output reg         input_switch,
  output reg         irq,
  output reg         wake_req
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] ctl_reg;
  reg [7:0] flags_reg;
  reg [7:0] pen_reg;
  reg [7:0] intctl_reg;
  reg [7:0] pdir_reg;
  reg [7:0] pdat_reg;
  reg [1:0] res_reg;
  reg [1:0] last_reg;
  reg [1:0] s1_reg;
  reg [1:0] s2_reg;
  reg [7:0] pin1_reg;
  reg [7:0] pin2_reg;

  wire [2:0] mode;
  wire       inv1;
  wire       inv2;
  wire       active;
  wire [1:0] res_now;
  wire       access;
  wire       wr;
  wire       sel_intctl;
  wire       sel_flags;
  wire       sel_ctl;
  wire       sel_pdat;
  wire       sel_pdir;
  wire       sel_pen;
  wire       mapped;
  wire       ctl_access;
  wire       mismatch;
  wire       set_flag;
  wire       pin_drive;
  wire [7:0] analog_mask;
  reg  [7:0] rd_next;

  assign mode = ctl_reg[2:0];
  assign inv1 = ctl_reg[`DCC_INV1_BIT];
  assign inv2 = ctl_reg[`DCC_INV2_BIT];

  // comparators powered in every mode but reset and off
  assign active = (mode != `DCC_MODE_RESET) &&
                  (mode != `DCC_MODE_OFF);

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // one wait state: pready rises in the second access cycle
  assign access = psel & penable & pready;
  assign wr     = access & pwrite;

  assign sel_intctl = (paddr[9:2] == `DCC_IDX_INTCTL);
  assign sel_flags  = (paddr[9:2] == `DCC_IDX_FLAGS);
  assign sel_ctl    = (paddr[9:2] == `DCC_IDX_CTL);
  assign sel_pdat   = (paddr[9:2] == `DCC_IDX_PDAT);
  assign sel_pdir   = (paddr[9:2] == `DCC_IDX_PDIR);
  assign sel_pen    = (paddr[9:2] == `DCC_IDX_PEN);

  assign mapped = (paddr[1:0] == 2'h0) &&
                  (paddr[11:10] == 2'h0) &&
                  (sel_intctl | sel_flags | sel_ctl |
                   sel_pdat | sel_pdir | sel_pen);

  // any read or write of the control register
  assign ctl_access = access & mapped & sel_ctl;

  // ----------------------------------------
  // result path
  // ----------------------------------------
  // raw is high when plus exceeds minus
  assign res_now = {s2_reg[1] ^ inv2,
                    s2_reg[0] ^ inv1};

  // compare against last accessed value
  assign mismatch = active &&
                    (res_reg != last_reg);

  // a change landing on a control access is lost
  assign set_flag = mismatch & ~ctl_access;

  assign pin_drive = (mode == `DCC_MODE_OUT_B) ||
                     (mode == `DCC_MODE_OUT_A);

  // pins that the mode leaves as analog inputs
  assign analog_mask =
    (mode == 3'h0) ? 8'h0F :
    (mode == 3'h1) ? 8'h0F :
    (mode == 3'h2) ? 8'h0F :
    (mode == 3'h3) ? 8'h07 :
    (mode == 3'h4) ? 8'h0F :
    (mode == 3'h5) ? 8'h06 :
    (mode == 3'h6) ? 8'h07 :
                     8'h00;

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_reg   <= 2'h0;
      s2_reg   <= 2'h0;
      pin1_reg <= 8'h00;
      pin2_reg <= 8'h00;
    end
    else
    begin
      s1_reg   <= {cmp2_raw, cmp1_raw};
      s2_reg   <= s1_reg;
      pin1_reg <= port_a_pins;
      pin2_reg <= pin1_reg;
    end
  end

  // ----------------------------------------
  // result bits and access latch
  // ----------------------------------------
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      res_reg  <= 2'h0;
      last_reg <= 2'h0;
    end
    else
    begin
      // powered-down comparators hold their results
      if (active)
      begin
        res_reg <= res_now;
      end
      if (ctl_access)
      begin
        last_reg <= res_reg;
      end
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl_reg    <= `DCC_RST_CTL;
      flags_reg  <= `DCC_RST_FLAGS;
      pen_reg    <= `DCC_RST_PEN;
      intctl_reg <= `DCC_RST_INTCTL;
      pdir_reg   <= `DCC_RST_PDIR;
      pdat_reg   <= `DCC_RST_PDAT;
    end
    else
    begin
      // only writes change control; sleep does not
      if (wr && mapped && sel_ctl)
      begin
        ctl_reg[5:0] <= pwdata[5:0];
      end
      if (wr && mapped && sel_pen)
      begin
        pen_reg <= pwdata[7:0] & `DCC_MASK_RSVD;
      end
      if (wr && mapped && sel_intctl)
      begin
        intctl_reg <= pwdata[7:0];
      end
      if (wr && mapped && sel_pdir)
      begin
        pdir_reg <= pwdata[7:0];
      end
      if (wr && mapped && sel_pdat)
      begin
        pdat_reg <= pwdata[7:0];
      end
      // hardware set wins over a software clear
      if (wr && mapped && sel_flags)
      begin
        flags_reg <= (pwdata[7:0] & `DCC_MASK_RSVD) |
                     {1'b0, set_flag, 6'h00};
      end
      else if (set_flag)
      begin
        flags_reg[`DCC_FLAG_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @*
  begin
    rd_next = 8'h00;
    if (sel_ctl)
    begin
      rd_next = {res_reg[1], res_reg[0], ctl_reg[5:0]};
    end
    else if (sel_flags)
    begin
      rd_next = flags_reg;
    end
    else if (sel_pen)
    begin
      rd_next = pen_reg;
    end
    else if (sel_intctl)
    begin
      rd_next = intctl_reg;
    end
    else if (sel_pdir)
    begin
      rd_next = pdir_reg;
    end
    else if (sel_pdat)
    begin
      rd_next = pin2_reg & ~analog_mask;
    end
  end

  // ----------------------------------------
  // apb answer
  // ----------------------------------------
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      if (psel && penable && !pready)
      begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= (mapped && !pwrite) ? {24'h000000, rd_next} : 32'h00000000;
      end
      else
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // analog steering and pins
  // ----------------------------------------
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmp_power_on <= 1'b0;
      vref_to_plus <= 1'b0;
      input_switch <= 1'b0;
      line3_out    <= 1'b0;
      line3_oe     <= 1'b0;
      line4_out    <= 1'b0;
      line4_oe     <= 1'b0;
    end
    else
    begin
      // comparators keep running while asleep
      cmp_power_on <= active;
      vref_to_plus <= (mode == `DCC_MODE_VREF);
      input_switch <= ctl_reg[`DCC_CIS_BIT] &&
                      ((mode == `DCC_MODE_OUT_A) ||
                       (mode == `DCC_MODE_VREF));
      // raw level, bypassing the synchroniser
      if (pin_drive)
      begin
        line3_out <= cmp1_raw ^ inv1;
        line4_out <= cmp2_raw ^ inv2;
      end
      else
      begin
        line3_out <= pdat_reg[`DCC_LINE3_BIT];
        line4_out <= pdat_reg[`DCC_LINE4_BIT];
      end
      line3_oe <= ~pdir_reg[`DCC_LINE3_BIT];
      line4_oe <= ~pdir_reg[`DCC_LINE4_BIT];
    end
  end

  // ----------------------------------------
  // interrupt and wake
  // ----------------------------------------
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq      <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      irq <= flags_reg[`DCC_FLAG_BIT] &
             pen_reg[`DCC_EN_BIT] &
             intctl_reg[`DCC_PERIPHERAL_INT_ENABLE_BIT] &
             intctl_reg[`DCC_GIE_BIT];
      wake_req <= sleep_mode &
                  flags_reg[`DCC_FLAG_BIT] &
                  pen_reg[`DCC_EN_BIT] &
                  intctl_reg[`DCC_PERIPHERAL_INT_ENABLE_BIT];
    end
  end

endmodule
`default_nettype wire

// ---- dcc_top_asserts.sv ----
// port checker of the dual comparator control block
// assumes it is bound onto dcc_top
`timescale 1ns/1ps
`default_nettype none
module dcc_asserts
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        line3_oe,
  input wire logic        line4_oe,
  input wire logic        cmp_power_on,
  input wire logic        vref_to_plus,
  input wire logic        input_switch,
  input wire logic        sleep_mode,
  input wire logic        wake_req,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire wr_done = psel && penable && pready && pwrite;
  a_one_wait:
    assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("late ready");
  a_err_ready:
    assert property (pslverr |-> pready) else $error("error without ready");
  a_rdata_idle:
    assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
  a_oe_after_write:
    assert property ($changed({line3_oe, line4_oe}) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("enable moved without write");
  a_reset_state:
    assert property ($rose(rstn) |-> !cmp_power_on && !vref_to_plus && !line3_oe && !irq)
    else $error("not reset state");
  a_vref_powered:
    assert property (vref_to_plus |-> cmp_power_on) else $error("reference while off");
  a_switch_powered:
    assert property (input_switch |-> cmp_power_on) else $error("switch while off");
  a_wake_asleep:
    assert property (wake_req |-> $past(sleep_mode)) else $error("wake while awake");
endmodule
bind dcc_top dcc_asserts i_chk (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .line3_oe(line3_oe), .line4_oe(line4_oe), .cmp_power_on(cmp_power_on),
  .vref_to_plus(vref_to_plus), .input_switch(input_switch), .sleep_mode(sleep_mode),
  .wake_req(wake_req), .irq(irq));
`default_nettype wire

// ---- dual_comparator_control_test.sv ----
// self-checking bench of the dual comparator control block
// assumes dcc_top, its register header and the comparator model
`timescale 1ns/1ps
`default_nettype none
`include "dcc_regs.vh"
module dual_comparator_control_test;
  logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rv;
  logic        pready, pslverr, se, raw1, raw2, l3o, l3e, l4o, l4e, pwr, vrp, isw, irq, wake;
  logic [7:0]  p1 = 0, m1 = 0, p2 = 0, m2 = 0, pins = 0, d;
  logic [1:0]  r;
  logic [7:0]  ri [5] = '{`DCC_IDX_CTL, `DCC_IDX_FLAGS, `DCC_IDX_PEN, `DCC_IDX_INTCTL,
                          `DCC_IDX_PDIR};
  logic [7:0]  re [5] = '{`DCC_RST_CTL, `DCC_RST_FLAGS, `DCC_RST_PEN, `DCC_RST_INTCTL,
                          `DCC_RST_PDIR};
  logic [7:0]  mk [8] = '{8'h0F, 8'h0F, 8'h0F, 8'h07, 8'h0F, 8'h06, 8'h07, 8'h00};
  int          n_fail = 0, n_tests = 0, i;
  always #5 sys_clk = ~sys_clk;
  dcc_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp1_raw(raw1), .cmp2_raw(raw2), .port_a_pins(pins),
    .sleep_mode(sleep_mode), .line3_out(l3o), .line3_oe(l3e), .line4_out(l4o),
    .line4_oe(l4e), .cmp_power_on(pwr), .vref_to_plus(vrp), .input_switch(isw), .irq(irq),
    .wake_req(wake));
  dcc_cmp_model i_cmp (.plus1(p1), .minus1(m1), .plus2(p2), .minus2(m2), .vref_sel(vrp),
    .vref_lvl(8'h80), .raw1(raw1), .raw2(raw2));
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits a bounded time for the answer
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] dat);
    int k;
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, dat};
    @(posedge sys_clk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      n_fail++;
      wrap_up;
    end
    rv = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask
  // expected result bits {second, first} from the current levels
  function automatic logic [1:0] res(input logic i2, input logic i1, input logic vr);
    return {((vr ? 8'h80 : p2) > m2) ^ i2, ((vr ? 8'h80 : p1) > m1) ^ i1};
  endfunction
  initial
  begin
    void'($urandom(90573));
    repeat (5) @(posedge sys_clk);
    rstn <= 1;
    @(posedge sys_clk);
    foreach (ri[j])
    begin
      apb(0, ri[j], 0);
      chk(rv, {24'h0, re[j]});
    end
    apb(1, 8'h40, 8'hFF);
    chk(se, 1);
    $display("test reset done");
    apb(1, `DCC_IDX_PDIR, 8'hE7);
    for (i = 0; i < 30; i++)
    begin
      {p1, m1, p2, m2} <= $urandom;
      d = {2'b11, 3'($urandom), 3'($urandom_range(1, 6))};
      apb(1, `DCC_IDX_CTL, d);
      repeat (5) @(posedge sys_clk);
      r = res(d[5], d[4], d[2:0] == 3'h2);
      apb(0, `DCC_IDX_CTL, 0);
      chk(rv, {24'h0, r, d[5:0]});
      chk({l4e, l3e, l4o, l3o}, {2'b11, (d[2:0] == 3'h1 || d[2:0] == 3'h6) ? r : 2'b00});
      chk({vrp, isw, pwr}, {d[2:0] == 3'h2, d[3] && d[2:0] < 3'h3, 1'b1});
    end
    pins <= $urandom;
    for (i = 0; i < 8; i++)
    begin
      apb(1, `DCC_IDX_CTL, 8'(i));
      apb(0, `DCC_IDX_PDAT, 0);
      chk(rv, {24'h0, pins & ~mk[i]});
    end
    $display("test modes done");
    m1 <= 8'h80;
    p1 <= 8'h10;
    apb(1, `DCC_IDX_CTL, 8'h01);
    repeat (6) @(posedge sys_clk);
    apb(0, `DCC_IDX_CTL, 0);
    apb(1, `DCC_IDX_FLAGS, 0);
    p1 <= 8'hF0;
    repeat (6) @(posedge sys_clk);
    apb(1, `DCC_IDX_FLAGS, 0);
    apb(0, `DCC_IDX_FLAGS, 0);
    chk(rv, 32'h40);
    apb(0, `DCC_IDX_CTL, 0);
    apb(1, `DCC_IDX_FLAGS, 0);
    apb(0, `DCC_IDX_FLAGS, 0);
    chk(rv, 32'h0);
    for (i = 0; i < 8; i += 7)
    begin
      apb(1, `DCC_IDX_CTL, 8'(i));
      apb(1, `DCC_IDX_FLAGS, 0);
      p1 <= p1 ^ 8'hE0;
      repeat (6) @(posedge sys_clk);
      apb(0, `DCC_IDX_FLAGS, 0);
      chk(rv, 32'h0);
      chk({29'h0, vrp, isw, pwr}, 32'h0);
    end
    $display("test flag done");
    apb(1, `DCC_IDX_CTL, 8'h37);
    apb(1, `DCC_IDX_FLAGS, 8'h40);
    sleep_mode <= 1;
    for (i = 0; i < 8; i++)
    begin
      apb(1, `DCC_IDX_PEN, {1'b0, i[0], 6'h0});
      apb(1, `DCC_IDX_INTCTL, {i[2:1], 6'h0});
      // irq and wake settle one edge after the enable write
      @(posedge sys_clk);
      chk({irq, wake}, {&i[2:0], i[0] & i[1]});
    end
    sleep_mode <= 0;
    apb(0, `DCC_IDX_CTL, 0);
    chk(rv & 32'h3F, 32'h37);
    $display("test interrupt done");
    wrap_up;
  end
endmodule
`default_nettype wire
